// ===== design/sensor_ctl_pkg.sv
// constants for the sensor command, rate, sleep and filter control block
// assumes a 100 MHz system clock and 16-bit serial frames from the host
package sensor_ctl_pkg;
	// register byte addresses, even byte of each word
	localparam logic [6:0] ADDR_AUX_DAC = 7'h30;
	localparam logic [6:0] ADDR_MISC = 7'h34;
	localparam logic [6:0] ADDR_SAMPLE_PERIOD = 7'h36;
	localparam logic [6:0] ADDR_RANGE_FILTER = 7'h38;
	localparam logic [6:0] ADDR_SLEEP = 7'h3a;
	localparam logic [6:0] ADDR_STATUS = 7'h3c;
	localparam logic [6:0] ADDR_COMMAND = 7'h3e;
	// reset values and read masks
	localparam logic [15:0] SAMPLE_PERIOD_RST = 16'h0001;
	localparam logic [15:0] RANGE_FILTER_RST = 16'h0402;
	localparam logic [15:0] MISC_RST = 16'h0000;
	localparam logic [15:0] MISC_MASK = 16'h07c7;
	localparam logic [15:0] DAC_MASK = 16'h0fff;
	// command bits
	localparam int CMD_AUTONULL = 0;
	localparam int CMD_FACTORY = 1;
	localparam int CMD_DAC_LATCH = 2;
	localparam int CMD_FLASH = 3;
	localparam int CMD_PRECISION = 4;
	localparam int CMD_SOFT_RESET = 7;
	// field positions
	localparam int MISC_ORIGIN_BIT = 6;
	localparam int MISC_ACCEL_COMP_BIT = 7;
	localparam int SP_TIMEBASE_BIT = 7;
	localparam int STATUS_FLASH_ERR_BIT = 2;
	localparam int STATUS_BUSY_BIT = 7;
	localparam int FRAME_WRITE_BIT = 15;
	localparam logic [7:0] FAST_MODE_MAX = 8'h09;
	// range codes and tap limits
	localparam logic [2:0] RANGE_300 = 3'h4;
	localparam logic [2:0] RANGE_150 = 3'h2;
	localparam logic [2:0] RANGE_75 = 3'h1;
	localparam logic [2:0] TAPS_MIN_150 = 3'h2;
	localparam logic [2:0] TAPS_MIN_75 = 3'h4;
	localparam logic [2:0] TAPS_MAX = 3'h6;
	// times
	localparam int CLK_PERIOD_NS = 10;
	localparam int MS_NS = 1000000;
	localparam int TB_FAST_NS = 610350;     // 0.61035 ms
	localparam int TB_SLOW_NS = 18921000;   // 18.921 ms
	localparam int FLASH_MS = 100;
	localparam int PRECISION_MS = 30000;
	localparam int SLEEP_STEP_MS = 500;     // 0.5 s per count
	localparam int MS_CYC_DEF = MS_NS / CLK_PERIOD_NS;
	localparam int TB_FAST_CYC_DEF = TB_FAST_NS / CLK_PERIOD_NS;
	localparam int TB_SLOW_CYC_DEF = TB_SLOW_NS / CLK_PERIOD_NS;
	typedef enum logic [2:0] {
		SEQ_IDLE, SEQ_FACTORY, SEQ_NULL, SEQ_PRECISION, SEQ_FLASH
	} seq_e;
endpackage

// ===== design/sensor_ctl.sv
// sensor command, sample rate, sleep and filter control with serial slave
// assumes a mode-3 serial host on SCLK_IN, 16-bit frames, datapath outside
`timescale 1ns/1ps
module sensor_ctl
	import sensor_ctl_pkg::*;
#(
	parameter int MS_CYCLES = MS_CYC_DEF,
	parameter int TB_FAST_CYCLES = TB_FAST_CYC_DEF,
	parameter int TB_SLOW_CYCLES = TB_SLOW_CYC_DEF
) (
	input wire logic CLK_IN,
	input wire logic RST_IN,
	input wire logic SCLK_IN,
	input wire logic CS_N_IN,
	input wire logic SDI_IN,
	output logic SDO_OUT,
	input wire logic FLASH_FAULT_IN,
	output logic SAMPLE_TICK_OUT,
	output logic FAST_MODE_OUT,
	output logic SLEEP_OUT,
	output logic ORIGIN_ALIGN_OUT,
	output logic ACCEL_COMP_OUT,
	output logic [2:0] RANGE_SEL_OUT,
	output logic [2:0] FILTER_LOG2_OUT,
	output logic [6:0] FILTER_TAPS_OUT,
	output logic [11:0] DAC_LEVEL_OUT,
	output logic FACTORY_CLEAR_OUT,
	output logic GYRO_NULL_LOAD_OUT,
	output logic PRECISION_OUT,
	output logic FLASH_WRITE_OUT,
	output logic SOFT_RESET_OUT
);
	// ---- link domain (SCLK_IN) ----
	logic [4:0] bit_cnt_r;
	logic [15:0] shift_r;
	logic [15:0] frame_r;
	logic frame_tog_r;
	logic sdo_r;
	logic [15:0] rd_word_r;

	// chip select high ends the frame, so a stopped clock leaves no residue
	always_ff @(posedge SCLK_IN or posedge CS_N_IN) begin
		if (CS_N_IN) begin
			bit_cnt_r <= 5'h00;
		end else begin
			bit_cnt_r <= bit_cnt_r + 5'h01;
		end
	end

	always_ff @(posedge SCLK_IN) begin
		shift_r <= {shift_r[14:0], SDI_IN};
		if (!CS_N_IN && bit_cnt_r == 5'h0f) begin
			frame_r <= {shift_r[14:0], SDI_IN};
		end
	end

	always_ff @(posedge SCLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			frame_tog_r <= 1'b0;
		end else if (!CS_N_IN && bit_cnt_r == 5'h0f) begin
			frame_tog_r <= ~frame_tog_r;
		end
	end

	// read word is held steady by the system side between frames
	always_ff @(negedge SCLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			sdo_r <= 1'b0;
		end else begin
			sdo_r <= rd_word_r[4'hf - bit_cnt_r[3:0]];
		end
	end
	assign SDO_OUT = sdo_r;

	// ---- crossings into the system domain ----
	logic tog_s1_r, tog_s2_r, tog_s3_r, cs_s1_r, cs_s2_r;
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			tog_s1_r <= 1'b0;
			tog_s2_r <= 1'b0;
			tog_s3_r <= 1'b0;
			cs_s1_r <= 1'b1;
			cs_s2_r <= 1'b1;
		end else begin
			tog_s1_r <= frame_tog_r;
			tog_s2_r <= tog_s1_r;
			tog_s3_r <= tog_s2_r;
			cs_s1_r <= CS_N_IN;
			cs_s2_r <= cs_s1_r;
		end
	end

	logic frame_new, wr_en;
	logic [6:0] fr_addr;
	logic [7:0] wr_data;
	assign frame_new = tog_s2_r ^ tog_s3_r;
	assign fr_addr = frame_r[14:8];
	assign wr_data = frame_r[7:0];
	assign wr_en = frame_new && frame_r[FRAME_WRITE_BIT];

	// software reset runs the same synchronous restart as the reset pin, except on the crossing, link-domain and soft_rst_r flops
	logic soft_rst_r, sys_rst;
	assign sys_rst = RST_IN | soft_rst_r;
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			soft_rst_r <= 1'b0;
		end else begin
			soft_rst_r <= wr_en && fr_addr == ADDR_COMMAND
				&& wr_data[CMD_SOFT_RESET];
		end
	end
	assign SOFT_RESET_OUT = soft_rst_r;

	function automatic logic [2:0] taps_fix(input logic [2:0] rng,
		input logic [2:0] taps);
		logic [2:0] t;
		t = (taps > TAPS_MAX) ? TAPS_MAX : taps;
		if (rng == RANGE_150 && t < TAPS_MIN_150) begin
			t = TAPS_MIN_150;
		end else if (rng == RANGE_75 && t < TAPS_MIN_75) begin
			t = TAPS_MIN_75;
		end
		return t;
	endfunction

	// ---- registers ----
	logic [15:0] misc_r, sp_r, dac_code_r;
	logic [2:0] range_r, taps_r;
	logic [7:0] sleep_cnt_r;
	logic [11:0] dac_level_r;
	logic cmd_wr, dac_latch;
	assign cmd_wr = wr_en && fr_addr == ADDR_COMMAND;
	assign dac_latch = cmd_wr && wr_data[CMD_DAC_LATCH];

	always_ff @(posedge CLK_IN) begin
		if (sys_rst) begin
			misc_r <= MISC_RST;
			sp_r <= SAMPLE_PERIOD_RST;
			dac_code_r <= 16'h0000;
			sleep_cnt_r <= 8'h00;
		end else if (wr_en) begin
			unique case (fr_addr)
				ADDR_MISC: misc_r[7:0] <= wr_data;
				ADDR_MISC + 7'h01: misc_r[15:8] <= wr_data;
				ADDR_SAMPLE_PERIOD: sp_r[7:0] <= wr_data;
				ADDR_SAMPLE_PERIOD + 7'h01: sp_r[15:8] <= wr_data;
				ADDR_AUX_DAC: dac_code_r[7:0] <= wr_data;
				ADDR_AUX_DAC + 7'h01: dac_code_r[15:8] <= wr_data;
				ADDR_SLEEP: sleep_cnt_r <= wr_data;
				default: ;
			endcase
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (sys_rst) begin
			range_r <= RANGE_FILTER_RST[10:8];
			taps_r <= RANGE_FILTER_RST[2:0];
		end else if (wr_en && fr_addr == ADDR_RANGE_FILTER) begin
			taps_r <= taps_fix(range_r, wr_data[2:0]);
		end else if (wr_en && fr_addr == ADDR_RANGE_FILTER + 7'h01
			&& (wr_data[2:0] == RANGE_300 || wr_data[2:0] == RANGE_150
			|| wr_data[2:0] == RANGE_75)) begin
			range_r <= wr_data[2:0];
			taps_r <= taps_fix(wr_data[2:0], taps_r);
		end
	end

	// separate latch keeps the output still across two byte writes
	always_ff @(posedge CLK_IN) begin
		if (sys_rst) begin
			dac_level_r <= 12'h000;
		end else if (dac_latch) begin
			dac_level_r <= dac_code_r[11:0];
		end
	end

	assign ORIGIN_ALIGN_OUT = misc_r[MISC_ORIGIN_BIT];
	assign ACCEL_COMP_OUT = misc_r[MISC_ACCEL_COMP_BIT];
	assign RANGE_SEL_OUT = range_r;
	assign FILTER_LOG2_OUT = taps_r;
	// datapath cascades two moving averages of this length
	assign FILTER_TAPS_OUT = 7'h01 << taps_r;
	assign DAC_LEVEL_OUT = dac_level_r;
	assign FAST_MODE_OUT = sp_r[7:0] <= FAST_MODE_MAX;

	// ---- millisecond prescaler ----
	logic [31:0] ms_cnt_r;
	logic ms_tick;
	assign ms_tick = ms_cnt_r == 32'(MS_CYCLES - 1);
	always_ff @(posedge CLK_IN) begin
		if (sys_rst || ms_tick) begin
			ms_cnt_r <= 32'h0000_0000;
		end else begin
			ms_cnt_r <= ms_cnt_r + 32'h0000_0001;
		end
	end

	// ---- command sequencer ----
	seq_e seq_r;
	logic [4:0] pend_r, pend_nxt, take;
	logic [31:0] wait_r;
	logic flash_err_r, null_load_r, fact_r;

	always_comb begin
		take = 5'h00;
		if (seq_r == SEQ_IDLE) begin
			// fixed order: factory, autonull, precision, flash
			if (pend_r[CMD_FACTORY]) begin
				// factory absorbs only a flash request; autonull still runs
				take = 5'h0a;
			end else if (pend_r[CMD_AUTONULL]) begin
				take = 5'h09;
			end else if (pend_r[CMD_PRECISION]) begin
				take = 5'h18;
			end else if (pend_r[CMD_FLASH]) begin
				take = 5'h08;
			end
		end
		pend_nxt = pend_r & ~take;
		if (cmd_wr) begin
			// set wins over the clear of the same cycle; unused bits dropped
			pend_nxt = pend_nxt | (wr_data[4:0] & 5'h1b);
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (sys_rst) begin
			pend_r <= 5'h00;
		end else if (!(cmd_wr && wr_data[CMD_SOFT_RESET])) begin
			pend_r <= pend_nxt;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (sys_rst) begin
			seq_r <= SEQ_IDLE;
			wait_r <= 32'h0000_0000;
			null_load_r <= 1'b0;
			fact_r <= 1'b0;
		end else begin
			null_load_r <= 1'b0;
			fact_r <= 1'b0;
			unique case (seq_r)
				SEQ_IDLE: begin
					if (take[CMD_FACTORY]) begin
						seq_r <= SEQ_FACTORY;
					end else if (take[CMD_AUTONULL]) begin
						seq_r <= SEQ_NULL;
					end else if (take[CMD_PRECISION]) begin
						seq_r <= SEQ_PRECISION;
						wait_r <= 32'(PRECISION_MS);
					end else if (take[CMD_FLASH]) begin
						seq_r <= SEQ_FLASH;
						wait_r <= 32'(FLASH_MS);
					end
				end
				SEQ_FACTORY: begin
					fact_r <= 1'b1;
					seq_r <= SEQ_FLASH;
					wait_r <= 32'(FLASH_MS);
				end
				SEQ_NULL: begin
					null_load_r <= 1'b1;
					seq_r <= SEQ_FLASH;
					wait_r <= 32'(FLASH_MS);
				end
				SEQ_PRECISION: begin
					if (ms_tick && wait_r == 32'h0000_0001) begin
						null_load_r <= 1'b1;
						seq_r <= SEQ_FLASH;
						wait_r <= 32'(FLASH_MS);
					end else if (ms_tick) begin
						wait_r <= wait_r - 32'h0000_0001;
					end
				end
				SEQ_FLASH: begin
					if (ms_tick && wait_r == 32'h0000_0001) begin
						seq_r <= SEQ_IDLE;
					end else if (ms_tick) begin
						wait_r <= wait_r - 32'h0000_0001;
					end
				end
				default: seq_r <= SEQ_IDLE;
			endcase
		end
	end

	logic flash_end;
	assign flash_end = seq_r == SEQ_FLASH && ms_tick
		&& wait_r == 32'h0000_0001;
	always_ff @(posedge CLK_IN) begin
		if (sys_rst) begin
			flash_err_r <= 1'b0;
		end else if (flash_end) begin
			flash_err_r <= FLASH_FAULT_IN;
		end
	end

	// the flash store copies the nonvolatile registers while this is high
	assign FLASH_WRITE_OUT = seq_r == SEQ_FLASH;
	assign PRECISION_OUT = seq_r == SEQ_PRECISION;
	assign GYRO_NULL_LOAD_OUT = null_load_r;
	assign FACTORY_CLEAR_OUT = fact_r;

	// ---- sleep ----
	logic sleep_r, cs_hi_seen_r, cs_lo_seen_r, sleep_start;
	logic [31:0] sleep_ms_r;
	assign sleep_start = wr_en && fr_addr == ADDR_SLEEP && wr_data != 8'h00;
	always_ff @(posedge CLK_IN) begin
		if (sys_rst) begin
			sleep_r <= 1'b0;
			sleep_ms_r <= 32'h0000_0000;
			cs_hi_seen_r <= 1'b0;
			cs_lo_seen_r <= 1'b0;
		end else if (sleep_start) begin
			sleep_r <= 1'b1;
			sleep_ms_r <= 32'(wr_data) * 32'(SLEEP_STEP_MS);
			cs_hi_seen_r <= 1'b0;
			cs_lo_seen_r <= 1'b0;
		end else if (sleep_r) begin
			// the writing frame's own select rise must not wake it
			cs_hi_seen_r <= cs_hi_seen_r | cs_s2_r;
			cs_lo_seen_r <= cs_lo_seen_r | (cs_hi_seen_r & ~cs_s2_r);
			if (cs_lo_seen_r && cs_s2_r) begin
				sleep_r <= 1'b0;
			end else if (ms_tick && sleep_ms_r == 32'h0000_0001) begin
				sleep_r <= 1'b0;
			end
			if (ms_tick) begin
				sleep_ms_r <= sleep_ms_r - 32'h0000_0001;
			end
		end
	end
	assign SLEEP_OUT = sleep_r;

	// ---- sample period generator ----
	logic [31:0] base_cnt_r, base_len;
	logic [6:0] mult_cnt_r;
	logic base_tick, tick_r;
	assign base_len = sp_r[SP_TIMEBASE_BIT] ? 32'(TB_SLOW_CYCLES)
		: 32'(TB_FAST_CYCLES);
	assign base_tick = base_cnt_r >= base_len - 32'h0000_0001;
	always_ff @(posedge CLK_IN) begin
		if (sys_rst || sleep_r) begin
			base_cnt_r <= 32'h0000_0000;
			mult_cnt_r <= 7'h00;
			tick_r <= 1'b0;
		end else begin
			tick_r <= 1'b0;
			if (base_tick) begin
				base_cnt_r <= 32'h0000_0000;
				if (mult_cnt_r >= sp_r[6:0]) begin
					mult_cnt_r <= 7'h00;
					tick_r <= 1'b1;
				end else begin
					mult_cnt_r <= mult_cnt_r + 7'h01;
				end
			end else begin
				base_cnt_r <= base_cnt_r + 32'h0000_0001;
			end
		end
	end
	assign SAMPLE_TICK_OUT = tick_r;

	// ---- read data for the next frame ----
	always_ff @(posedge CLK_IN) begin
		if (sys_rst) begin
			rd_word_r <= 16'h0000;
		end else if (frame_new && !frame_r[FRAME_WRITE_BIT]) begin
			unique case ({fr_addr[6:1], 1'b0})
				ADDR_MISC: rd_word_r <= misc_r & MISC_MASK;
				ADDR_SAMPLE_PERIOD: rd_word_r <= {8'h00, sp_r[7:0]};
				ADDR_RANGE_FILTER: rd_word_r <= {5'h00, range_r, 5'h00, taps_r};
				ADDR_SLEEP: rd_word_r <= {8'h00, sleep_cnt_r};
				ADDR_AUX_DAC: rd_word_r <= dac_code_r & DAC_MASK;
				ADDR_STATUS: rd_word_r <= (16'(seq_r != SEQ_IDLE)
					<< STATUS_BUSY_BIT)
					| (16'(flash_err_r) << STATUS_FLASH_ERR_BIT);
				default: rd_word_r <= 16'h0000;
			endcase
		end
	end

	// ---- checks ----
	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (RST_IN);

	logic [31:0] flash_cyc_r, gap_r;
	logic gap_ok_r;
	always_ff @(posedge CLK_IN) begin
		flash_cyc_r <= FLASH_WRITE_OUT ? flash_cyc_r + 32'h0000_0001
			: 32'h0000_0000;
		if (RST_IN || tick_r) begin
			gap_r <= 32'h0000_0001;
			gap_ok_r <= !RST_IN;
		end else begin
			gap_r <= gap_r + 32'h0000_0001;
			if (wr_en || sleep_r || soft_rst_r) begin
				gap_ok_r <= 1'b0;
			end
		end
	end

	chk_origin_follow: assert property (wr_en
		&& fr_addr == ADDR_MISC && !soft_rst_r
		|=> ORIGIN_ALIGN_OUT == $past(wr_data[MISC_ORIGIN_BIT]))
		else $error("origin align bit not taken");
	chk_zero_cmd_idle: assert property (cmd_wr
		&& wr_data == 8'h00 && seq_r == SEQ_IDLE && pend_r == 5'h00
		&& !soft_rst_r |=> pend_r == 5'h00 && !SOFT_RESET_OUT)
		else $error("zero command started something");
	// the first millisecond may be partial, so the length spans one ms
	chk_flash_length: assert property ($fell(FLASH_WRITE_OUT)
		&& !$past(sys_rst)
		|-> flash_cyc_r >= 32'((FLASH_MS - 1) * MS_CYCLES + 1)
		&& flash_cyc_r <= 32'(FLASH_MS * MS_CYCLES))
		else $error("flash update length wrong");
	chk_auto_flash: assert property ((seq_r == SEQ_NULL
		|| seq_r == SEQ_FACTORY) && !soft_rst_r |=> seq_r == SEQ_FLASH)
		else $error("no flash after calibration");
	chk_flash_flag: assert property (flash_end
		&& !soft_rst_r |=> flash_err_r == $past(FLASH_FAULT_IN))
		else $error("flash error flag wrong");
	chk_dac_hold: assert property (!dac_latch
		&& !soft_rst_r |=> $stable(DAC_LEVEL_OUT))
		else $error("dac output moved without latch");
	chk_soft_reset: assert property (SOFT_RESET_OUT
		|=> sp_r == SAMPLE_PERIOD_RST && seq_r == SEQ_IDLE && !sleep_r
		&& DAC_LEVEL_OUT == 12'h000)
		else $error("soft reset did not restart");
	chk_tick_period: assert property (tick_r
		&& gap_ok_r |-> gap_r == (sp_r[SP_TIMEBASE_BIT]
		? 32'(TB_SLOW_CYCLES) : 32'(TB_FAST_CYCLES))
		* 32'({25'h0, sp_r[6:0]} + 32'h0000_0001))
		else $error("sample period wrong");
	chk_sleep_expire: assert property (sleep_r
		&& ms_tick && sleep_ms_r == 32'h0000_0001 && !sleep_start
		&& !soft_rst_r |=> !sleep_r ##1 !sleep_r)
		else $error("sleep did not end on time");
	chk_min_taps: assert property ((range_r != RANGE_150
		|| taps_r >= TAPS_MIN_150) && (range_r != RANGE_75
		|| taps_r >= TAPS_MIN_75) && taps_r <= TAPS_MAX)
		else $error("tap setting below range minimum");

	cov_flash_done: cover property (flash_end);
	cov_cs_wake: cover property (sleep_r && cs_lo_seen_r && cs_s2_r);
	cov_dac_latch: cover property (dac_latch ##1 $changed(DAC_LEVEL_OUT));
	cov_precision: cover property ($fell(PRECISION_OUT));
endmodule

// ===== testbench/spi_host_model.sv
// serial host model: mode-3 master, 16-bit frames, msb first
// assumes the device samples sdi on sclk rise and shifts sdo on sclk fall
`timescale 1ns/1ps
module spi_host_model (
	output logic SCLK_OUT,
	output logic CS_N_OUT,
	output logic SDI_OUT,
	input wire logic SDO_IN
);
	initial begin
		SCLK_OUT = 1'b1;
		SDI_OUT = 1'b0;
		// select rises after time zero so the bit counter clear is seen
		CS_N_OUT = 1'b0;
		#1 CS_N_OUT = 1'b1;
	end
	// one frame; sclk stands high outside frames, 64 ns period
	// the host timing is fixed and does not scale with the bench's shortened time base
	task automatic xfer(input logic [15:0] w, output logic [15:0] r);
		#7 CS_N_OUT = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			#32 SCLK_OUT = 1'b0;
			SDI_OUT = w[i];
			#32 SCLK_OUT = 1'b1;
			r[i] = SDO_IN;
		end
		// quick release so that a sleep write is honoured
		#32 CS_N_OUT = 1'b1;
		// released data line shows the inverse, not a stale value
		SDI_OUT = ~w[0];
		// frame spacing lets the read word settle
		#1000;
	endtask
	task automatic cs_pulse();
		#7 CS_N_OUT = 1'b0;
		#200 CS_N_OUT = 1'b1;
		#1000;
	endtask
endmodule

// ===== testbench/sensor_command_rate_sleep_filter_ctl_tb.sv
// self-checking bench for the command, rate, sleep and filter block
// assumes the host model drives the link; long counts shortened by parameter
`timescale 1ns/1ps
module sensor_command_rate_sleep_filter_ctl_tb;
	import sensor_ctl_pkg::*;
	localparam int MSC = 10;
	localparam int TBF = 7;
	localparam int TBS = 20;
	localparam logic [7:0] SPV [4] = '{8'h01, 8'h09, 8'h0a, 8'h82};
	// range byte, tap byte, expected range, expected m
	localparam logic [15:0] FT [6] = '{16'h1214, 16'h1716, 16'h2022,
		16'h3022, 16'h4040, 16'h4343};
	logic clk, rst, fault, sclk, csn, sdi;
	logic sdo, tick, fast, slp, org, acc, fclr, nul, prec, fl, srst;
	logic [2:0] rng, m;
	logic [6:0] taps;
	logic [11:0] dac;
	int err_total, compares, cyc = 1, last_t, tick_per, n_tick, n_sr;
	int t_fact, t_null, t_fl, fl_cyc, slp_cyc;

	sensor_ctl #(.MS_CYCLES(MSC), .TB_FAST_CYCLES(TBF),
		.TB_SLOW_CYCLES(TBS)) DUT (
		.CLK_IN(clk), .RST_IN(rst), .SCLK_IN(sclk), .CS_N_IN(csn),
		.SDI_IN(sdi), .SDO_OUT(sdo), .FLASH_FAULT_IN(fault),
		.SAMPLE_TICK_OUT(tick), .FAST_MODE_OUT(fast), .SLEEP_OUT(slp),
		.ORIGIN_ALIGN_OUT(org), .ACCEL_COMP_OUT(acc),
		.RANGE_SEL_OUT(rng), .FILTER_LOG2_OUT(m), .FILTER_TAPS_OUT(taps),
		.DAC_LEVEL_OUT(dac), .FACTORY_CLEAR_OUT(fclr),
		.GYRO_NULL_LOAD_OUT(nul), .PRECISION_OUT(prec),
		.FLASH_WRITE_OUT(fl), .SOFT_RESET_OUT(srst));
	spi_host_model host (.SCLK_OUT(sclk), .CS_N_OUT(csn), .SDI_OUT(sdi),
		.SDO_IN(sdo));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (tick === 1'b1) begin
			tick_per <= cyc - last_t;
			last_t <= cyc;
			n_tick <= n_tick + 1;
		end
		if (fclr === 1'b1)
			t_fact <= cyc;
		if (nul === 1'b1)
			t_null <= cyc;
		if (srst === 1'b1)
			n_sr <= n_sr + 1;
		if (fl === 1'b1) begin
			fl_cyc <= fl_cyc + 1;
			if (fl_cyc == 0)
				t_fl <= cyc;
		end
		if (slp === 1'b1)
			slp_cyc <= slp_cyc + 1;
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic clr();
		t_fact = 0;
		t_null = 0;
		t_fl = 0;
		fl_cyc = 0;
		slp_cyc = 0;
		n_sr = 0;
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [15:0] r;
		@(posedge clk) #1;
		host.xfer({1'b1, a, d}, r);
	endtask
	task automatic rd(input logic [6:0] a, output logic [15:0] v);
		logic [15:0] r;
		@(posedge clk) #1;
		host.xfer({1'b0, a, 8'h00}, r);
		host.xfer(16'h0000, v);
	endtask
	task automatic close_out();
		if (err_total == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic t_reset();
		logic [15:0] v;
		check(rng, RANGE_300);
		check({m, taps}, {3'h2, 7'h04});
		check({fast, slp, prec, fl, dac}, 16'h8000);
		rd(ADDR_SAMPLE_PERIOD, v);
		check(v, SAMPLE_PERIOD_RST);
		rd(ADDR_RANGE_FILTER, v);
		check(v, RANGE_FILTER_RST);
		rd(ADDR_COMMAND, v);
		check(v, 16'h0000);
		rd(7'h50, v);
		check(v, 16'h0000);
	endtask
	task automatic t_misc();
		wr(ADDR_MISC, 8'h40);
		check({acc, org}, 2'b01);
		wr(ADDR_MISC, 8'h80);
		check({acc, org}, 2'b10);
	endtask
	task automatic t_rate();
		int e;
		for (int i = 0; i < 4; i++) begin
			e = (SPV[i][6:0] + 1) * (SPV[i][7] ? TBS : TBF);
			wr(ADDR_SAMPLE_PERIOD, SPV[i]);
			repeat (250) @(posedge clk);
			#1;
			check(tick_per, e);
			check(fast, SPV[i] <= FAST_MODE_MAX);
		end
	endtask
	task automatic t_cmd();
		wr(ADDR_AUX_DAC, 8'h34);
		wr(ADDR_AUX_DAC + 7'h1, 8'h0a);
		check(dac, 12'h000);
		wr(ADDR_COMMAND, 8'h04);
		check(dac, 12'ha34);
		clr();
		wr(ADDR_COMMAND, 8'h60);
		wr(ADDR_COMMAND + 7'h1, 8'hff);
		wr(ADDR_COMMAND, 8'h00);
		check(t_fact + t_null + fl_cyc + n_sr + prec, 0);
	endtask
	task automatic t_flash();
		logic [15:0] v;
		for (int f = 1; f >= 0; f--) begin
			@(posedge clk) #1 fault = f[0];
			clr();
			wr(ADDR_COMMAND, 8'h08);
			repeat (FLASH_MS * MSC + 100) @(posedge clk);
			#1;
			check(fl_cyc inside {[(FLASH_MS-1)*MSC:FLASH_MS*MSC]}, 1);
			// flag read only after the update has ended
			rd(ADDR_STATUS, v);
			check(v[STATUS_FLASH_ERR_BIT], f[0]);
		end
	endtask
	task automatic t_order();
		clr();
		wr(ADDR_COMMAND, 8'h03);
		repeat (FLASH_MS * MSC + 200) @(posedge clk);
		#1;
		// factory and its flash first, then autonull and a second flash
		check(t_fact != 0, 1'b1);
		check(t_fl >= t_fact, 1'b1);
		check(t_null > t_fl, 1'b1);
		check(fl_cyc > FLASH_MS * MSC, 1'b1);
	endtask
	task automatic t_abort();
		wr(ADDR_RANGE_FILTER, 8'h05);
		clr();
		wr(ADDR_COMMAND, 8'h10);
		repeat (500) @(posedge clk);
		#1;
		check(prec, 1'b1);
		wr(ADDR_COMMAND, 8'h80);
		check({prec, m, dac}, {1'b0, 3'h2, 12'h000});
		check(n_sr, 1);
		check(t_null, 0);
		clr();
		wr(ADDR_COMMAND, 8'h81);
		check(t_null + fl_cyc, 0);
		check(n_sr, 1);
	endtask
	task automatic t_filter();
		logic [15:0] e;
		for (int i = 0; i < 6; i++) begin
			e = FT[i];
			wr(ADDR_RANGE_FILTER + 7'h1, {4'h0, e[15:12]});
			wr(ADDR_RANGE_FILTER, {4'h0, e[11:8]});
			check(rng, e[6:4]);
			check(m, e[2:0]);
			check(taps, 7'h01 << e[2:0]);
		end
	endtask
	task automatic t_sleep();
		int n;
		clr();
		wr(ADDR_SLEEP, 8'h02);
		check(slp, 1'b1);
		n = n_tick;
		for (int i = 0; i < 11000 && slp === 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		check(slp, 1'b0);
		check(n_tick, n);
		check(slp_cyc inside {[999*MSC:1000*MSC+2]}, 1);
		wr(ADDR_SLEEP, 8'h05);
		check(slp, 1'b1);
		repeat (100) @(posedge clk);
		host.cs_pulse();
		check(slp, 1'b0);
	endtask

	initial begin
		rst = 1'b0;
		fault = 1'b0;
		// a rise after time zero so the link flops see their clear
		#1 rst = 1'b1;
		repeat (10) @(posedge clk);
		#1 rst = 1'b0;
		@(posedge clk) #1;
		t_reset();
		t_misc();
		t_rate();
		t_cmd();
		t_flash();
		t_order();
		t_filter();
		t_abort();
		t_sleep();
		close_out();
	end
	// a hang is cut at about two and a half times the expected run
	initial begin
		#600000;
		err_total++;
		close_out();
	end
endmodule
